// >>> rtl/ext_io_pkg.sv
package ext_io_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned CMD_N  = 7;
    localparam int unsigned PIN_N  = 8;

    localparam logic [ADDR_W-1:0] CTRL_OFS   = 5'h00;
    localparam logic [ADDR_W-1:0] LIMIT_OFS  = 5'h04;
    localparam logic [ADDR_W-1:0] SEQ_OFS    = 5'h08;
    localparam logic [ADDR_W-1:0] EVENT_OFS  = 5'h0c;
    localparam logic [ADDR_W-1:0] PINS_OFS   = 5'h10;

    localparam int unsigned CTRL_SRC_BIT  = 0;
    localparam int unsigned CTRL_OUT_BIT  = 1;
    localparam int unsigned CTRL_BUSY_BIT = 2;
    localparam int unsigned CTRL_TRIG_BIT = 3;

    localparam int unsigned CMD_OFF_BIT   = 0;
    localparam int unsigned CMD_ON_BIT    = 1;
    localparam int unsigned CMD_START_BIT = 2;
    localparam int unsigned CMD_STOP_BIT  = 3;
    localparam int unsigned CMD_HOLD_BIT  = 4;
    localparam int unsigned CMD_BR1_BIT   = 5;
    localparam int unsigned CMD_BR2_BIT   = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [3:0] LIMIT_RESET = 4'h0;
    localparam logic [2:0] SEQ_RESET   = 3'h0;

    typedef struct packed {
        logic       trigger;
        logic [2:0] seq_sync;
        logic       busy;
        logic       limiting;
        logic       output_on;
        logic       source_on;
    } status_pins_t;

    typedef struct packed {
        logic branch2_n;
        logic branch1_n;
        logic hold_n;
        logic stop_n;
        logic start_n;
        logic on_n;
        logic off_n;
        logic spare_n;
    } cmd_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axil_rsp_t;

endpackage

// >>> rtl/pin_fall_detect.sv
`timescale 1ns/1ns
module pin_fall_detect #(
    parameter int unsigned W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] fall;
    } fd_state_t;

    fd_state_t s_q;
    fd_state_t s_d;

    if (W < 1)
    begin : g_chk
        $error("pin_fall_detect needs W of at least 1");
    end

    always_comb
    begin
        s_d      = s_q;
        s_d.s1   = pin;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        // one pulse per high-to-low step; a held low repeats nothing
        s_d.fall = s_q.s3 & ~s_q.s2;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // pins idle high via pull-ups, so reset high: no false edge
            s_q.s1   <= '1;
            s_q.s2   <= '1;
            s_q.s3   <= '1;
            s_q.fall <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level = s_q.s2;
    assign fall  = s_q.fall;
endmodule // pin_fall_detect

// >>> rtl/ext_control_io.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module ext_control_io
    import ext_io_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire ext_io_pkg::axil_req_t    axil_req,
    output ext_io_pkg::axil_rsp_t         axil_rsp,
    input  wire ext_io_pkg::cmd_pins_t    cmd_pins,
    output ext_io_pkg::status_pins_t      status_pins,
    output logic                          output_enabled,
    output logic [ext_io_pkg::CMD_N-1:0]  cmd_event
);
    import ext_io_pkg::*;

    typedef struct packed {
        axil_rsp_t         rsp;
        logic              have_aw;
        logic              have_w;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              src_on;
        logic              out_on;
        logic              busy;
        logic              trig;
        logic [3:0]        limit;
        logic [2:0]        seq;
        logic [CMD_N-1:0]  events;
        logic [CMD_N-1:0]  pulse;
        status_pins_t      pins;
    } top_state_t;

    top_state_t       s_q;
    top_state_t       s_d;
    logic [PIN_N-1:0] pin_level;
    logic [PIN_N-1:0] pin_fall;
    logic [CMD_N-1:0] cmd_fall;

    // refuse package edits that the decode below cannot serve
    if (PIN_N != CMD_N + 1)
    begin : g_chk_pin_n
        $error("expects one spare input plus one per command");
    end

    if (CMD_N > 8)
    begin : g_chk_cmd_n
        $error("event clears use byte lane 0 only");
    end

    if (PIN_N > 32)
    begin : g_chk_pin_w
        $error("pin levels must fit one read word");
    end

    if (ADDR_W < 5)
    begin : g_chk_addr_w
        $error("offsets need at least five address bits");
    end

    if ((CTRL_OFS[1:0] | LIMIT_OFS[1:0] | SEQ_OFS[1:0] | EVENT_OFS[1:0]
        | PINS_OFS[1:0]) != 2'h0)
    begin : g_chk_align
        $error("register offsets must be word aligned");
    end

    if (CTRL_OFS == LIMIT_OFS || CTRL_OFS == SEQ_OFS
        || CTRL_OFS == EVENT_OFS || CTRL_OFS == PINS_OFS
        || LIMIT_OFS == SEQ_OFS || LIMIT_OFS == EVENT_OFS
        || LIMIT_OFS == PINS_OFS || SEQ_OFS == EVENT_OFS
        || SEQ_OFS == PINS_OFS || EVENT_OFS == PINS_OFS)
    begin : g_chk_ofs
        $error("register offsets must differ");
    end

    if (CTRL_SRC_BIT > 7 || CTRL_OUT_BIT > 7 || CTRL_BUSY_BIT > 7
        || CTRL_TRIG_BIT > 7)
    begin : g_chk_ctrl
        $error("control fields must sit in byte lane 0");
    end

    if (CMD_OFF_BIT >= CMD_N || CMD_ON_BIT >= CMD_N
        || CMD_OFF_BIT == CMD_ON_BIT)
    begin : g_chk_cmd_bits
        $error("off and on need distinct event bits");
    end

    if (CMD_START_BIT >= CMD_N || CMD_STOP_BIT >= CMD_N
        || CMD_HOLD_BIT >= CMD_N || CMD_BR1_BIT >= CMD_N
        || CMD_BR2_BIT >= CMD_N)
    begin : g_chk_seq_bits
        $error("sequence commands need event bits below CMD_N");
    end

    if ($bits(cmd_pins_t) != PIN_N)
    begin : g_chk_pins_t
        $error("command pin struct must match PIN_N");
    end

    if ($bits(LIMIT_RESET) != 4)
    begin : g_chk_limit
        $error("four limiters feed the limiter pin");
    end

    if ($bits(SEQ_RESET) != 3)
    begin : g_chk_seq
        $error("three sequence sync bits expected");
    end

    pin_fall_detect #(
        .W     (PIN_N)
    ) u_fall (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (cmd_pins),
        .level   (pin_level),
        .fall    (pin_fall)
    );

    // spare input is only readable; it issues no command
    assign cmd_fall = pin_fall[PIN_N-1:1];

    function automatic logic [31:0] read_word(
        input top_state_t       st,
        input logic [ADDR_W-1:0] a,
        input logic [PIN_N-1:0] lv
    );
        logic [31:0] r;
        r = 32'h0;
        unique case (a)
            CTRL_OFS:
            begin
                r[CTRL_SRC_BIT]  = st.src_on;
                r[CTRL_OUT_BIT]  = st.out_on;
                r[CTRL_BUSY_BIT] = st.busy;
                r[CTRL_TRIG_BIT] = st.trig;
            end
            LIMIT_OFS:
            begin
                r[3:0] = st.limit;
            end
            SEQ_OFS:
            begin
                r[2:0] = st.seq;
            end
            EVENT_OFS:
            begin
                r[CMD_N-1:0] = st.events;
            end
            PINS_OFS:
            begin
                r[PIN_N-1:0] = lv;
            end
            default:
            begin
                r = 32'h0;
            end
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic m;
        unique case (a)
            CTRL_OFS, LIMIT_OFS, SEQ_OFS, EVENT_OFS, PINS_OFS:
            begin
                m = 1'b1;
            end
            default:
            begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction

    always_comb
    begin
        logic [7:0] wb;
        logic       do_wr;
        logic       off_cmd;
        logic       on_cmd;
        wb      = 8'h0;
        do_wr   = 1'b0;
        off_cmd = 1'b0;
        on_cmd  = 1'b0;
        s_d     = s_q;

        // read channel
        if (s_q.rsp.rvalid && axil_req.rready)
        begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (s_q.rsp.arready && axil_req.arvalid)
        begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = read_word(s_q, axil_req.araddr, pin_level);
            s_d.rsp.rresp  = mapped(axil_req.araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // write channels, taken in either order
        if (s_q.rsp.bvalid && axil_req.bready)
        begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.rsp.awready && axil_req.awvalid)
        begin
            s_d.have_aw = 1'b1;
            s_d.waddr   = axil_req.awaddr;
        end
        if (s_q.rsp.wready && axil_req.wvalid)
        begin
            s_d.have_w = 1'b1;
            s_d.wdata  = axil_req.wdata;
            s_d.wstrb  = axil_req.wstrb;
        end
        if (s_q.have_aw && s_q.have_w && !s_q.rsp.bvalid)
        begin
            s_d.have_aw    = 1'b0;
            s_d.have_w     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = mapped(s_q.waddr) ? RESP_OKAY : RESP_SLVERR;
            // all fields sit in byte lane 0
            do_wr = s_q.wstrb[0];
            wb    = s_q.wdata[7:0];
        end
        s_d.rsp.awready = !s_d.have_aw && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.have_w && !s_d.rsp.bvalid;

        if (do_wr)
        begin
            unique case (s_q.waddr)
                CTRL_OFS:
                begin
                    s_d.src_on = wb[CTRL_SRC_BIT];
                    s_d.out_on = wb[CTRL_OUT_BIT];
                    s_d.busy   = wb[CTRL_BUSY_BIT];
                    s_d.trig   = wb[CTRL_TRIG_BIT];
                end
                LIMIT_OFS:
                begin
                    s_d.limit = wb[3:0];
                end
                SEQ_OFS:
                begin
                    s_d.seq = wb[2:0];
                end
                EVENT_OFS:
                begin
                    s_d.events = s_q.events & ~wb[CMD_N-1:0];
                end
                default:
                begin
                    s_d.events = s_q.events;
                end
            endcase
        end

        // pin commands override a same-cycle register write
        off_cmd = cmd_fall[CMD_OFF_BIT];
        on_cmd  = cmd_fall[CMD_ON_BIT];
        // off beats on when both fall together: the safe choice
        if (off_cmd)
        begin
            s_d.out_on = 1'b0;
        end
        else if (on_cmd)
        begin
            s_d.out_on = 1'b1;
        end
        // set wins over a clear in the same cycle
        s_d.events = s_d.events | cmd_fall;
        s_d.pulse  = cmd_fall;

        s_d.pins.source_on = s_q.src_on;
        s_d.pins.busy      = s_q.busy;
        s_d.pins.output_on = s_q.out_on;
        s_d.pins.limiting  = |s_q.limit;
        s_d.pins.seq_sync  = s_q.seq;
        s_d.pins.trigger   = s_q.trig;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q        <= '0;
            s_q.limit  <= LIMIT_RESET;
            s_q.seq    <= SEQ_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign axil_rsp       = s_q.rsp;
    assign status_pins    = s_q.pins;
    assign output_enabled = s_q.out_on;
    assign cmd_event      = s_q.pulse;
endmodule // ext_control_io

// >>> testbench/ext_io_checker_properties.sv
`timescale 1ns/1ns
module ext_io_checker
    import ext_io_pkg::*;
(
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire ext_io_pkg::axil_req_t        axil_req,
    input wire ext_io_pkg::axil_rsp_t        axil_rsp,
    input wire ext_io_pkg::cmd_pins_t        cmd_pins,
    input wire ext_io_pkg::status_pins_t     status_pins,
    input wire logic                         output_enabled,
    input wire logic [ext_io_pkg::CMD_N-1:0] cmd_event
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_off; $fell(cmd_pins.off_n) |-> ##[2:5] cmd_event[0]; endproperty
    a_off: assert property (p_off) else $error("off lost");
    property p_on; $fell(cmd_pins.on_n) |-> ##[2:5] cmd_event[1]; endproperty
    a_on: assert property (p_on) else $error("on lost");
    property p_one; (cmd_event & $past(cmd_event)) == '0; endproperty
    a_one: assert property (p_one) else $error("event repeated");
    property p_pin; status_pins.output_on == $past(output_enabled); endproperty
    a_pin: assert property (p_pin) else $error("output pin wrong");
    property p_kill; cmd_event[0] |-> ##[0:1] !output_enabled; endproperty
    a_kill: assert property (p_kill) else $error("off ignored");
    property p_aw; axil_rsp.bvalid |-> !axil_rsp.awready; endproperty
    a_aw: assert property (p_aw) else $error("aw ready with b");
    property p_ar; axil_rsp.rvalid |-> !axil_rsp.arready; endproperty
    a_ar: assert property (p_ar) else $error("ar ready with r");
    property p_rv;
        $rose(axil_rsp.rvalid) |-> $past(axil_req.arvalid && axil_rsp.arready);
    endproperty
    a_rv: assert property (p_rv) else $error("read answer unasked");
    c_off: cover property (cmd_event[0]);
    c_on: cover property (cmd_event[1]);
    c_err: cover property (axil_rsp.bvalid && axil_rsp.bresp == RESP_SLVERR);
endmodule // ext_io_checker
bind ext_control_io ext_io_checker chk_u (.aclk, .aresetn, .axil_req,
    .axil_rsp, .cmd_pins, .status_pins, .output_enabled, .cmd_event);

// >>> testbench/ext_pin_driver.sv
`timescale 1ns/1ns
module ext_pin_driver
    import ext_io_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             go,
    input  wire logic [7:0]       mask,
    output ext_io_pkg::cmd_pins_t pins
);
    logic [3:0] left_q = 4'h0;
    logic [7:0] low_q  = 8'h00;
    // released lines float up: inputs are pulled up
    assign pins = ~(left_q != 4'h0 ? low_q : 8'h00);
    always @(posedge aclk)
    begin
        if (go)
        begin
            left_q <= 4'h8;
            low_q  <= mask;
        end
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
    end
endmodule // ext_pin_driver

// >>> testbench/external_control_io_logic_tb.sv
`timescale 1ns/1ns
module external_control_io_logic_tb;
    import ext_io_pkg::*;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    axil_req_t    req = '{wstrb: 4'hf, default: '0};
    axil_rsp_t    rsp;
    cmd_pins_t    pins;
    status_pins_t st;
    logic         oen;
    logic [6:0]   evt;
    logic         go = 1'b0;
    logic [7:0]   mask = 8'h00;
    logic [31:0]  seed = 32'h6c91;
    logic [1:0]   r;
    logic [31:0]  q;
    logic [31:0]  v;
    logic [6:0]   last_evt = 7'h0;
    logic         exp_on;
    int           miscompares = 0;
    int           cmp_count = 0;
    int           pulses = 0;
    int           p0;
    int           order[8] = '{2, 1, 3, 4, 5, 6, 7, 0};

    ext_control_io dut_u (.aclk, .aresetn, .axil_req(req), .axil_rsp(rsp),
        .cmd_pins(pins), .status_pins(st), .output_enabled(oen),
        .cmd_event(evt));
    ext_pin_driver ctl_u (.aclk, .go, .mask, .pins);

    initial forever #4 aclk = ~aclk;
    always @(posedge aclk) pulses <= pulses + $countones(evt);
    always @(posedge aclk) if (evt != 7'h0) last_evt <= evt;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] exp_pins(input logic [31:0] v);
        return {v[3], v[10:8], v[2], |v[7:4], v[1], v[0]};
    endfunction

    task chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
        cmp_count++;
        if (seen !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", nm, e, seen);
        end
    endtask

    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // decide on settled values, release only after the edge that took it
    task bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, tr, done;
        done = 0;
        // an edge passes, so no signal is set twice in one step
        @(posedge aclk);
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        req.awvalid <= wr;
        req.wvalid <= wr;
        req.bready <= wr;
        req.arvalid <= !wr;
        req.rready <= !wr;
        for (int n = 0; n < 64 && !done; n++)
        begin
            @(negedge aclk);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tr = req.arvalid & rsp.arready;
            done = wr ? rsp.bvalid : rsp.rvalid;
            r = wr ? rsp.bresp : rsp.rresp;
            q = rsp.rdata;
            @(posedge aclk);
            if (ta) req.awvalid <= 0;
            if (tw) req.wvalid <= 0;
            if (tr) req.arvalid <= 0;
            if (done) req.bready <= 0;
            if (done) req.rready <= 0;
        end
        if (!done)
        begin
            miscompares++;
            give_verdict;
        end
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++)
        begin
            bus(0, 5'(i * 4), 0);
            chk("reset reg", {r, q}, {RESP_OKAY, 32'h0});
        end
        // idle pins float high through their pull-ups
        bus(0, PINS_OFS, 0);
        chk("pins reg", {r, q}, {RESP_OKAY, 32'hff});
        bus(1, 5'h14, 32'h5);
        chk("bad wr", r, RESP_SLVERR);
        bus(0, 5'h14, 0);
        chk("bad rd", {r, q}, {RESP_SLVERR, 32'h0});
        $display("test regs done");
        // first four writes light one limiter each, the fifth none
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            v = i < 5 ? (seed & ~32'hf0) | ((32'h10 << i) & 32'hf0) : seed;
            v = v & 32'h7ff;
            for (int k = 0; k < 3; k++)
                bus(1, 5'(k * 4), (v >> (k * 4)) & 32'hf);
            repeat (2) @(posedge aclk);
            chk("status", st, exp_pins(v));
        end
        $display("test status done");
        bus(1, CTRL_OFS, 32'h0);
        exp_on = 0;
        // on before off so the off has something to undo; spare last
        foreach (order[j])
        begin
            p0 = pulses;
            mask <= 8'h1 << order[j];
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            repeat (20) @(posedge aclk);
            exp_on = order[j] == 2 ? 1'b1 : order[j] == 1 ? 1'b0 : exp_on;
            chk("out pin", st.output_on, exp_on);
            chk("out en", oen, exp_on);
            chk("pulses", pulses - p0, order[j] != 0);
            // spare adds no event, so the branch 2 pulse stays last
            chk("event pin", last_evt,
                order[j] ? 7'h1 << (order[j] - 1) : 7'h40);
            bus(0, EVENT_OFS, 0);
            chk("event", q, order[j] ? 1 << (order[j] - 1) : 0);
            bus(1, EVENT_OFS, q);
        end
        $display("test commands done");
        give_verdict;
    end
endmodule // external_control_io_logic_tb
